// file: design/auxc_consts.vh
`ifndef AUXC_CONSTS_VH
`define AUXC_CONSTS_VH

// ==========================================================================
// Register offsets.
// ==========================================================================
`define AUXC_OFS_CONV_CTRL 8'h93
`define AUXC_OFS_THR0 8'h94
`define AUXC_OFS_THR1 8'h95
`define AUXC_OFS_THR2 8'h96
`define AUXC_OFS_THR3 8'h97
`define AUXC_OFS_RB_A 8'ha9
`define AUXC_OFS_RB_B 8'haa
`define AUXC_OFS_POWER 8'hc0
`define AUXC_OFS_AUX_CFG 8'hcd
`define AUXC_OFS_RB1 8'hd6
`define AUXC_OFS_RB2 8'hd7

// ==========================================================================
// Field positions and reset values.
// ==========================================================================
`define AUXC_CTRL_SRC1_LSB 0
`define AUXC_CTRL_SRC2_LSB 3
`define AUXC_CTRL_AVG1_BIT 6
`define AUXC_CTRL_AVG2_BIT 7
`define AUXC_CTRL_LEN_LSB 8
`define AUXC_CTRL_RESET 16'h0000
`define AUXC_THR_RESET 16'h0000
`define AUXC_POWER_RESET 16'h0000
`define AUXC_CFG_RESET 16'h0000
`define AUXC_POWER_BIAS_BIT 6
`define AUXC_CFG_SQ_CH_BIT 0
`define AUXC_RB_HIGH_BIT 10
`define AUXC_RB_LOW_BIT 11
`define AUXC_SRC_OFF 3'h0
`define AUXC_SRC_MAX 3'h4
`define AUXC_ROUND_HALF 19'h00080

// ==========================================================================
// Timing: one conversion per channel every conversion period.
// ==========================================================================
`define AUXC_CLK_MHZ 200
`define AUXC_CONV_TIME_NS 10000
`define AUXC_CONV_CYCLES ((`AUXC_CONV_TIME_NS * `AUXC_CLK_MHZ) / 1000)
`define AUXC_CONV_LAST 16'h07cf

`endif

// file: design/auxc_top.v
`timescale 1ns/1ps
`include "auxc_consts.vh"
// Summary of operation
// - Each channel takes its input from the pin its own source field selects.
// - A channel converts continuously while its source is valid, never while off.
// - Converters run only while the reference power bit 6 is set.
// - Averaging enabled by control bits; averaging length resets to zero.
// - New average is old plus (sample minus old) over two to (length plus one).
// - Length usable up to seven, giving the sample 0.390625 percent weight.
// - Per-channel high and low thresholds compare the averaged or raw value.
// - Event on first rise past high or first fall past low only.
// - A high event re-arms low and a low event re-arms high.
// - Readback word holds the result and the threshold status together.
// - A channel with thresholds can act as the squelch comparator.
// - In quadrature mode squelch comes from the processing path; channels stay free.
module auxc_top (
  input wire clk_sys,
  input wire resetn,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata,
  input wire [9:0] ain0,
  input wire [9:0] ain1,
  input wire [9:0] ain2,
  input wire [9:0] ain3,
  input wire iq_mode,
  input wire iq_squelch,
  output reg [1:0] irq_high,
  output reg [1:0] irq_low,
  output reg [1:0] conv_active,
  output reg squelch_out
);

  // ========================================================================
  // Functions.
  // ========================================================================

  // Tells whether a source code names an input pin.
  function src_valid;
    input [2:0] src;
    begin
      src_valid = (src != `AUXC_SRC_OFF) && (src <= `AUXC_SRC_MAX);
    end
  endfunction

  // One rolling-average step with 8 fraction bits and rounding.
  // Adding half a step before the shift rounds to nearest, so a steady input settles to within half an LSB of the sample.
  function [17:0] avg_step;
    input [17:0] avg;
    input [9:0] smp;
    input [2:0] len;
    reg signed [19:0] diff;
    reg signed [19:0] step;
    begin
      diff = $signed({2'b00, smp, 8'h00}) - $signed({2'b00, avg});
      step = (diff + (20'sd1 <<< len)) >>> ({1'b0, len} + 4'd1);
      avg_step = avg + step[17:0];
    end
  endfunction

  // Rounds the average back to a 10-bit result, saturating at full scale.
  function [9:0] avg_result;
    input [17:0] avg;
    reg [18:0] tmp;
    begin
      tmp = {1'b0, avg} + `AUXC_ROUND_HALF;
      avg_result = tmp[18] ? 10'h3ff : tmp[17:8];
    end
  endfunction

  // ========================================================================
  // Reset release and input synchronisers.
  // ========================================================================
  reg rst_s1_q;
  reg rst_s2_q;
  wire rst_n;

  // Releases the asynchronous reset through two flip-flops.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  // Every other flop resets from this copy, so all of them leave reset on the same edge.
  assign rst_n = rst_s2_q;

  reg [39:0] pin_s1_q;
  reg [39:0] pin_s2_q;

  // Brings the converter pin words into the clock domain.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 40'h0000000000;
      pin_s2_q <= 40'h0000000000;
    end else begin
      pin_s1_q <= {ain3, ain2, ain1, ain0};
      pin_s2_q <= pin_s1_q;
    end
  end

  reg [39:0] pin_s3_q;
  reg [39:0] pin_word_q;

  // Takes a pin word only once it has held for two cycles.
  // A word caught while its bits are still changing thus never reaches a channel.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_s3_q <= 40'h0000000000;
      pin_word_q <= 40'h0000000000;
    end else begin
      pin_s3_q <= pin_s2_q;
      if (pin_s2_q == pin_s3_q) begin
        pin_word_q <= pin_s2_q;
      end
    end
  end

  // Picks the pin word a source code selects.
  function [9:0] pin_sel;
    input [39:0] pins;
    input [2:0] src;
    begin
      case (src)
        3'h1: pin_sel = pins[9:0];
        3'h2: pin_sel = pins[19:10];
        3'h3: pin_sel = pins[29:20];
        3'h4: pin_sel = pins[39:30];
        // Codes five to seven select no pin and read as zero.
        default: pin_sel = 10'h000;
      endcase
    end
  endfunction

  // ========================================================================
  // Register file.
  // ========================================================================
  reg [15:0] ctrl_q;
  reg [15:0] power_q;
  reg [15:0] cfg_q;
  reg [9:0] thr_high_q [0:1];
  reg [9:0] thr_low_q [0:1];
  reg [1:0] newsrc_q;
  wire [2:0] src1;
  wire [2:0] src2;
  wire [2:0] avg_len;
  wire bias_on;
  wire ctrl_wr;

  assign src1 = ctrl_q[`AUXC_CTRL_SRC1_LSB +: 3];
  assign src2 = ctrl_q[`AUXC_CTRL_SRC2_LSB +: 3];
  assign avg_len = ctrl_q[`AUXC_CTRL_LEN_LSB +: 3];
  assign bias_on = power_q[`AUXC_POWER_BIAS_BIT];
  assign ctrl_wr = reg_wr && (reg_addr == `AUXC_OFS_CONV_CTRL);

  // Stores host writes; a changed source flags its channel for a fresh start.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `AUXC_CTRL_RESET;
      power_q <= `AUXC_POWER_RESET;
      cfg_q <= `AUXC_CFG_RESET;
      thr_high_q[0] <= 10'h000;
      thr_low_q[0] <= 10'h000;
      thr_high_q[1] <= 10'h000;
      thr_low_q[1] <= 10'h000;
      newsrc_q <= 2'b11;
    end else begin
      newsrc_q <= 2'b00;
      if (ctrl_wr) begin
        ctrl_q <= reg_wdata;
        newsrc_q[0] <= (reg_wdata[`AUXC_CTRL_SRC1_LSB +: 3] != src1);
        newsrc_q[1] <= (reg_wdata[`AUXC_CTRL_SRC2_LSB +: 3] != src2);
      end
      if (reg_wr) begin
        case (reg_addr)
          `AUXC_OFS_THR0: thr_high_q[0] <= reg_wdata[9:0];
          `AUXC_OFS_THR1: thr_low_q[0] <= reg_wdata[9:0];
          `AUXC_OFS_THR2: thr_high_q[1] <= reg_wdata[9:0];
          `AUXC_OFS_THR3: thr_low_q[1] <= reg_wdata[9:0];
          `AUXC_OFS_POWER: power_q <= reg_wdata;
          `AUXC_OFS_AUX_CFG: cfg_q <= reg_wdata;
          // Writes to read-only or unknown offsets change nothing.
          default: ;
        endcase
      end
    end
  end

  // ========================================================================
  // Conversion timer.
  // ========================================================================
  // The timer never stops, so a newly started channel waits at most one period.
  localparam [15:0] CONV_LAST = `AUXC_CONV_LAST;
  reg [15:0] timer_q;
  wire tick;

  assign tick = (timer_q == CONV_LAST);

  // Free-running period counter; each wrap is one conversion on every active channel.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timer_q <= 16'h0000;
    end else if (tick) begin
      timer_q <= 16'h0000;
    end else begin
      timer_q <= timer_q + 16'h0001;
    end
  end

  // ========================================================================
  // Channel datapath: averaging, thresholds and arming.
  // ========================================================================
  reg [17:0] avg_q [0:1];
  reg [9:0] res_q [0:1];
  reg [1:0] first_q;
  reg [1:0] arm_high_q;
  reg [1:0] arm_low_q;
  reg [1:0] above_q;
  reg [1:0] below_q;
  reg [1:0] run;
  reg [2:0] csrc [0:1];
  reg [9:0] smp [0:1];
  reg [17:0] nxt_avg [0:1];
  reg [9:0] val [0:1];
  integer c;
  integer n; // Loop index of the combinational process only.

  // Works out each channel's sample, next average and compare value.
  always @* begin
    csrc[0] = src1;
    csrc[1] = src2;
    for (n = 0; n < 2; n = n + 1) begin
      run[n] = bias_on && src_valid(csrc[n]);
      smp[n] = pin_sel(pin_word_q, csrc[n]);
      if (ctrl_q[`AUXC_CTRL_AVG1_BIT + n] && !first_q[n]) begin
        nxt_avg[n] = avg_step(avg_q[n], smp[n], avg_len);
      end else begin
        nxt_avg[n] = {smp[n], 8'h00};
      end
      val[n] = avg_result(nxt_avg[n]);
    end
  end

  // Runs a conversion per active channel on each tick and checks thresholds.
  // A source change or a stopped channel wins over a tick in the same cycle.
  // A stale sample therefore never fires an event.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avg_q[0] <= 18'h00000;
      avg_q[1] <= 18'h00000;
      res_q[0] <= 10'h000;
      res_q[1] <= 10'h000;
      first_q <= 2'b11;
      arm_high_q <= 2'b11;
      arm_low_q <= 2'b11;
      above_q <= 2'b00;
      below_q <= 2'b00;
      irq_high <= 2'b00;
      irq_low <= 2'b00;
      conv_active <= 2'b00;
    end else begin
      conv_active <= run;
      irq_high <= 2'b00;
      irq_low <= 2'b00;
      for (c = 0; c < 2; c = c + 1) begin
        if (newsrc_q[c] || !run[c]) begin
          first_q[c] <= 1'b1;
          arm_high_q[c] <= 1'b1;
          arm_low_q[c] <= 1'b1;
        end else if (tick) begin
          first_q[c] <= 1'b0;
          avg_q[c] <= nxt_avg[c];
          res_q[c] <= val[c];
          above_q[c] <= (val[c] > thr_high_q[c]);
          below_q[c] <= (val[c] < thr_low_q[c]);
          if (val[c] > thr_high_q[c] && arm_high_q[c]) begin
            irq_high[c] <= 1'b1;
            arm_high_q[c] <= 1'b0;
            arm_low_q[c] <= 1'b1;
          end else if (val[c] < thr_low_q[c] && arm_low_q[c]) begin
            irq_low[c] <= 1'b1;
            arm_low_q[c] <= 1'b0;
            arm_high_q[c] <= 1'b1;
          end
        end
      end
    end
  end

  // ========================================================================
  // Squelch output.
  // ========================================================================

  // Tracks the chosen channel's hysteresis state, or the processing path in quadrature mode.
  // The arming state already holds the hysteresis, so no extra filter is needed.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      squelch_out <= 1'b0;
    end else if (iq_mode) begin
      squelch_out <= iq_squelch;
    end else begin
      squelch_out <= !arm_high_q[cfg_q[`AUXC_CFG_SQ_CH_BIT]];
    end
  end

  // ========================================================================
  // Readback.
  // ========================================================================

  // Packs a channel's result and threshold status into one word.
  function [15:0] rb_word;
    input [9:0] res;
    input above;
    input below;
    begin
      rb_word = {4'h0, below, above, res};
    end
  endfunction

  // Returns the addressed word one cycle after a read strobe; others read zero.
  // A read never touches the arming state, so the host may poll freely.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `AUXC_OFS_RB1, `AUXC_OFS_RB_A: reg_rdata <= rb_word(res_q[0], above_q[0], below_q[0]);
        `AUXC_OFS_RB2, `AUXC_OFS_RB_B: reg_rdata <= rb_word(res_q[1], above_q[1], below_q[1]);
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

endmodule // auxc_top

// file: tb/auxc_monitor.sv
`timescale 1ns/1ps
// ==========================================
// Port checker
// ==========================================
module auxc_monitor (
  input wire clk_sys,
  input wire resetn,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire iq_mode,
  input wire iq_squelch,
  input wire [1:0] irq_high,
  input wire [1:0] irq_low,
  input wire [1:0] conv_active,
  input wire squelch_out
);
  reg [10:0] gap_q;
  reg [1:0] hi_q;
  reg [1:0] lo_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Counts cycles since the last event and keeps each channel's last event kind.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gap_q <= 11'h7ff;
      hi_q <= 2'b00;
      lo_q <= 2'b00;
    end else begin
      gap_q <= ((irq_high | irq_low) != 2'b00) ? 11'h000 : ((gap_q == 11'h7ff) ? gap_q : gap_q + 11'h001);
      hi_q <= (hi_q | irq_high) & ~irq_low & conv_active;
      lo_q <= (lo_q | irq_low) & ~irq_high & conv_active;
    end
  end
  evt_spacing_a: assert property ((irq_high | irq_low) != 2'b00 |-> gap_q >= 11'h7cf)
    else $error("events closer than one conversion period");
  one_kind_a: assert property ((irq_high & irq_low) == 2'b00)
    else $error("high and low event together");
  high_alt0_a: assert property (irq_high[0] |-> !hi_q[0])
    else $error("channel one high event repeated");
  high_alt1_a: assert property (irq_high[1] |-> !hi_q[1])
    else $error("channel two high event repeated");
  low_alt_a: assert property (irq_low != 2'b00 |-> (irq_low & lo_q) == 2'b00)
    else $error("low event repeated");
  evt_needs_run_a: assert property (((irq_high | irq_low) & ~(conv_active | $past(conv_active))) == 2'b00)
    else $error("event on an idle channel");
  sq_iq_on_a: assert property ((iq_mode && iq_squelch) [*2] |-> squelch_out)
    else $error("squelch output not following path in iq mode");
  sq_iq_off_a: assert property ((iq_mode && !iq_squelch) [*2] |-> !squelch_out)
    else $error("squelch output set in iq mode");
  sq_source_a: assert property (!iq_mode && !$past(iq_mode) && !$past(iq_mode, 2) && $rose(squelch_out) |->
    ($past(irq_high) != 2'b00 || irq_high != 2'b00))
    else $error("squelch rose without high event");
  rdata_hold_a: assert property (!$past(reg_rd) && !$past(reg_rd, 2) |-> $stable(reg_rdata))
    else $error("read data changed without a read");
  run_needs_write_a: assert property ((conv_active & ~$past(conv_active)) != 2'b00 |->
    ($past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3)))
    else $error("channel started without a write");
  cover property (irq_high[0]);
  cover property (irq_low[0]);
  cover property (irq_high[1]);
  cover property (iq_mode && squelch_out);
endmodule // auxc_monitor
bind auxc_top auxc_monitor i_mon (.clk_sys(clk_sys), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .iq_mode(iq_mode), .iq_squelch(iq_squelch), .irq_high(irq_high), .irq_low(irq_low),
  .conv_active(conv_active), .squelch_out(squelch_out));

// file: tb/auxc_pin_model.sv
`timescale 1ns/1ps
// ==========================================
// Analogue source model
// ==========================================
module auxc_pin_model (
  input wire [39:0] level,
  output wire [9:0] ain0,
  output wire [9:0] ain1,
  output wire [9:0] ain2,
  output wire [9:0] ain3
);
  // Pins settle a few ns after a level change, unrelated to the clock.
  assign #3 ain0 = level[9:0];
  assign #3 ain1 = level[19:10];
  assign #3 ain2 = level[29:20];
  assign #3 ain3 = level[39:30];
endmodule // auxc_pin_model

// file: tb/tb_auxc_top.sv
`timescale 1ns/1ps
// ==========================================
// Testbench
// ==========================================
module tb_auxc_top;
  reg clk_sys, resetn, reg_wr, reg_rd, iq_mode, iq_squelch;
  reg [7:0] reg_addr, rnd;
  reg [15:0] reg_wdata;
  reg [39:0] level;
  reg [1:0] rd_q = 2'b00;
  wire [15:0] reg_rdata;
  wire [9:0] ain0, ain1, ain2, ain3;
  wire [1:0] irq_high, irq_low, conv_active;
  wire squelch_out;
  logic [15:0] rd_exp[$];
  logic [3:0] irq_exp[$];
  int num_errors, compares, i, k;
  auxc_top i_dut (.clk_sys(clk_sys), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ain0(ain0), .ain1(ain1), .ain2(ain2), .ain3(ain3),
    .iq_mode(iq_mode), .iq_squelch(iq_squelch), .irq_high(irq_high), .irq_low(irq_low),
    .conv_active(conv_active), .squelch_out(squelch_out));
  auxc_pin_model i_pins (.level(level), .ain0(ain0), .ain1(ain1), .ain2(ain2), .ain3(ain3));
  // Compares one value and counts the outcome.
  task automatic check(input [15:0] got, input [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Register write and read, each a one-cycle strobe.
  task wr(input [7:0] a, input [15:0] d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task rd(input [7:0] a, input [15:0] e);
    rd_exp.push_back(e);
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask
  // Waits a bounded time for the next event pulse.
  task wait_irq;
    i = 0;
    do begin
      @(negedge clk_sys);
      i++;
    end while (i < 2200 && (irq_high | irq_low) === 2'b00);
    if (i >= 2200) num_errors++;
  endtask
  function automatic [7:0] lfsr(input [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task give_verdict;
    if (rd_exp.size() != 0 || irq_exp.size() != 0) num_errors++;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Clock.
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Result watcher: takes the oldest note whenever read data or an event appears.
  always @(posedge clk_sys) rd_q <= {rd_q[0], reg_rd};
  always @(negedge clk_sys) begin
    if (rd_q[1]) check(reg_rdata, rd_exp.pop_front());
    if ((irq_high | irq_low) !== 2'b00)
      check({12'h000, irq_high, irq_low}, irq_exp.size() ? {12'h000, irq_exp.pop_front()} : 16'hffff);
  end
  // Watchdog.
  initial begin
    #300000;
    num_errors++;
    give_verdict;
  end
  // Main sequence.
  initial begin
    {resetn, reg_wr, reg_rd, iq_mode, iq_squelch} = 5'h00;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    level = 40'h0;
    rnd = 8'h5d;
    repeat (2) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (3) @(negedge clk_sys);
    wr(8'h94, 16'h0064);
    wr(8'h95, 16'h0014);
    wr(8'h96, 16'h012c);
    wr(8'h97, 16'h0050);
    rd(8'hd6, 16'h0000);
    rd(8'h55, 16'h0000);
    wr(8'h93, 16'h0019);
    level = {10'h000, 10'h032, 10'h000, 10'h0c8};
    repeat (2100) @(negedge clk_sys);
    check(16'(conv_active), 16'h0000);
    $display("test bias_off done");
    irq_exp.push_back(4'b0110);
    wr(8'hc0, 16'h0040);
    repeat (3) @(negedge clk_sys);
    check(16'(conv_active), 16'h0003);
    wait_irq;
    rd(8'hd6, 16'h04c8);
    rd(8'hd7, 16'h0832);
    rd(8'ha9, 16'h04c8);
    $display("test first_events done");
    for (k = 0; k < 2; k++) begin
      rnd = lfsr(rnd);
      level[39:10] = {rnd, 2'b01, 10'h050 + {3'h0, rnd[6:0]}, 2'b10, rnd};
      repeat (2000) @(negedge clk_sys);
    end
    irq_exp.push_back(4'b0001);
    level[9:0] = 10'h00a;
    wait_irq;
    irq_exp.push_back(4'b0100);
    level[9:0] = 10'h0c8;
    wait_irq;
    $display("test rearm done");
    wr(8'h93, 16'h0018);
    repeat (3) @(negedge clk_sys);
    check(16'(conv_active), 16'h0002);
    irq_exp.push_back(4'b0100);
    wr(8'h93, 16'h0059);
    wait_irq;
    level[9:0] = 10'h064;
    repeat (2010) @(negedge clk_sys);
    rd(8'hd6, 16'h0496);
    $display("test average done");
    check(16'(squelch_out), 16'h0001);
    iq_mode = 1'b1;
    repeat (3) @(negedge clk_sys);
    check(16'(squelch_out), 16'h0000);
    iq_squelch = 1'b1;
    repeat (3) @(negedge clk_sys);
    check(16'(squelch_out), 16'h0001);
    $display("test squelch done");
    wr(8'hcd, 16'h0001);
    level[39:30] = 10'h190;
    repeat (8) @(negedge clk_sys);
    irq_exp.push_back(4'b1000);
    wr(8'h93, 16'h01a0);
    wait_irq;
    level[39:30] = 10'h000;
    repeat (2010) @(negedge clk_sys);
    rd(8'hd7, 16'h012c);
    iq_mode = 1'b0;
    repeat (3) @(negedge clk_sys);
    check(16'(squelch_out), 16'h0001);
    wr(8'hcd, 16'h0000);
    repeat (3) @(negedge clk_sys);
    check(16'(squelch_out), 16'h0000);
    $display("test channel_two done");
    give_verdict;
  end
endmodule // tb_auxc_top
